// file: rtl/gate_seq_pkg.sv
// Shared constants and types of the gate-drive sequencer
package gate_seq_pkg;
  // **********************************************************************
  // Widths
  // **********************************************************************
  localparam int CUR_W = 6;
  localparam int TIME_W = 8;
  localparam int DLY_W = 8;
  // **********************************************************************
  // Timing
  // **********************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int BD_PERIOD_NS = 80;
  localparam int BD_DIV = (BD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // **********************************************************************
  // Current codes and modes
  // **********************************************************************
  localparam logic [CUR_W-1:0] CUR_MIN = 6'h00;
  localparam logic [CUR_W-1:0] CUR_STEP_SMALL = 6'h01;
  localparam logic [CUR_W-1:0] CUR_STEP_LARGE = 6'h02;
  localparam logic [CUR_W-1:0] CUR_RESET = 6'h00;
  localparam logic [DLY_W-1:0] DLY_RESET = 8'h00;
  localparam logic [DLY_W-1:0] DLY_MAX = 8'hFF;
  localparam logic [1:0] MODE_NO_PRE = 2'h0;
  localparam int MODE_ADAPT_BIT = 1;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ON_CCP = 4'h1,
    ST_ON_PRE = 4'h2,
    ST_ON_CHG = 4'h3,
    ST_ON_POST = 4'h4,
    ST_ON_HOLD = 4'h5,
    ST_OFF_SYM = 4'h6,
    ST_OFF_PRE = 4'h7,
    ST_OFF_DIS = 4'h8,
    ST_OFF_FW = 4'h9,
    ST_OFF_HOLD = 4'hA
  } seq_state_t;
endpackage

// file: rtl/phase_timer.sv
// Down counter in bridge-driver clock ticks
`timescale 1ns/1ns
module phase_timer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  output logic done
);
  logic [W-1:0] count;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= '0;
    else if (load)
      count <= load_value;
    else if (tick && count != '0)
      count <= count - 1'b1;
  end

  assign done = (count == '0);
endmodule

// file: rtl/adaptive_current.sv
// Self-adapting gate current code with optional two-cycle filter
`timescale 1ns/1ns
module adaptive_current #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic init_load,
  input wire logic [W-1:0] init_code,
  input wire logic [W-1:0] max_code,
  input wire logic adapt_en,
  input wire logic filter_sel,
  input wire logic step_sel,
  input wire logic update,
  input wire logic longer,
  input wire logic shorter,
  output logic [W-1:0] code
);
  logic prev_long;
  logic prev_short;
  logic up;
  logic down;
  logic [W-1:0] step;
  logic [W-1:0] base;
  logic [W:0] sum;
  logic [W:0] floor_sum;

  assign step = step_sel ? gate_seq_pkg::CUR_STEP_LARGE : gate_seq_pkg::CUR_STEP_SMALL;
  assign base = (code > max_code) ? max_code : code;
  // Filter needs both this and the previous result on the same side
  assign up = update && adapt_en && longer && (!filter_sel || prev_long);
  assign down = update && adapt_en && shorter && (!filter_sel || prev_short);
  assign sum = {1'b0, base} + {1'b0, step};
  assign floor_sum = {1'b0, gate_seq_pkg::CUR_MIN} + {1'b0, step};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      code <= gate_seq_pkg::CUR_RESET;
    else if (init_load)
      code <= (init_code < max_code) ? init_code : max_code;
    else if (up)
      code <= (sum > {1'b0, max_code}) ? max_code : sum[W-1:0];
    else if (down)
      code <= ({1'b0, base} < floor_sum) ? gate_seq_pkg::CUR_MIN : base - step;
  end

  // History is cleared on init so a stale result cannot pair with a new one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_long <= 1'b0;
      prev_short <= 1'b0;
    end
    else if (init_load)
    begin
      prev_long <= 1'b0;
      prev_short <= 1'b0;
    end
    else if (update)
    begin
      prev_long <= longer;
      prev_short <= shorter;
    end
  end
endmodule

// file: rtl/gate_drive_sequencer.sv
// Gate-drive phase sequencer for one PWM half-bridge
`timescale 1ns/1ns
module gate_drive_sequencer #(
  parameter int CUR_W = gate_seq_pkg::CUR_W,
  parameter int TIME_W = gate_seq_pkg::TIME_W,
  parameter int DLY_W = gate_seq_pkg::DLY_W,
  parameter int BD_DIV = gate_seq_pkg::BD_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwm_input,
  input wire logic pwm_on_low_side,
  input wire logic bridge_pwm_enable,
  input wire logic enable_write_strobe,
  input wire logic active_freewheel_sel,
  input wire logic [1:0] gate_control_mode,
  input wire logic adapt_filter_sel,
  input wire logic adapt_step_sel,
  input wire logic [CUR_W-1:0] max_current_code,
  input wire logic [CUR_W-1:0] charge_current_code,
  input wire logic [CUR_W-1:0] discharge_current_code,
  input wire logic [CUR_W-1:0] freewheel_current_code,
  input wire logic [CUR_W-1:0] initial_precharge_code,
  input wire logic [CUR_W-1:0] initial_predischarge_code,
  input wire logic [TIME_W-1:0] precharge_duration,
  input wire logic [TIME_W-1:0] predischarge_duration,
  input wire logic [TIME_W-1:0] freewheel_protect_time,
  input wire logic [TIME_W-1:0] active_protect_time,
  input wire logic [TIME_W-1:0] drain_source_filter_time,
  input wire logic [DLY_W-1:0] target_turn_on_delay,
  input wire logic [DLY_W-1:0] target_turn_off_delay,
  input wire logic switch_node_high_threshold,
  input wire logic switch_node_low_threshold,
  output logic hs_source,
  output logic hs_sink,
  output logic [CUR_W-1:0] hs_current,
  output logic ls_source,
  output logic ls_sink,
  output logic [CUR_W-1:0] ls_current,
  output logic [DLY_W-1:0] turn_on_delay,
  output logic [DLY_W-1:0] turn_off_delay,
  output logic [CUR_W-1:0] adaptive_precharge_current,
  output logic [CUR_W-1:0] adaptive_predischarge_current
);
  // **********************************************************************
  // Declarations
  // **********************************************************************
  gate_seq_pkg::seq_state_t state;
  gate_seq_pkg::seq_state_t next_state;
  logic pwm_q;
  logic rise;
  logic fall;
  logic bd_tick;
  logic [$clog2(BD_DIV+1)-1:0] bd_count;
  logic phase_load;
  logic [TIME_W-1:0] phase_value;
  logic phase_done;
  logic prot_load;
  logic prot_done;
  logic on_trip;
  logic fw_ok;
  logic no_pre;
  logic [CUR_W-1:0] ramp;
  logic [CUR_W-1:0] pre_code;
  logic [CUR_W-1:0] predis_code;
  logic [DLY_W-1:0] on_cnt;
  logic [DLY_W-1:0] off_cnt;
  logic off_meas;
  logic on_update;
  logic off_update;
  logic on_long;
  logic off_long;
  logic init_load;
  logic act_src;
  logic act_snk;
  logic [CUR_W-1:0] act_code;
  logic fw_src;
  logic fw_snk;
  logic [CUR_W-1:0] fw_code;

  if (BD_DIV < 1 || CUR_W < 2 || TIME_W < 1 || DLY_W < 1)
  begin : bad_params
    $error("gate_drive_sequencer: unsupported parameter values");
  end

  // **********************************************************************
  // Edges, comparators and bridge-driver tick
  // **********************************************************************
  assign rise = pwm_input && !pwm_q;
  assign fall = !pwm_input && pwm_q;
  // Mirrored mapping swaps which comparator means on and off
  assign on_trip = pwm_on_low_side ? switch_node_low_threshold : switch_node_high_threshold;
  assign fw_ok = pwm_on_low_side ? switch_node_high_threshold : switch_node_low_threshold;
  assign no_pre = (gate_control_mode == gate_seq_pkg::MODE_NO_PRE);
  assign init_load = enable_write_strobe && bridge_pwm_enable;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwm_q <= 1'b0;
    else
      pwm_q <= pwm_input;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bd_count <= '0;
      bd_tick <= 1'b0;
    end
    else if (bd_count == $bits(bd_count)'(BD_DIV - 1))
    begin
      bd_count <= '0;
      bd_tick <= 1'b1;
    end
    else
    begin
      bd_count <= bd_count + 1'b1;
      bd_tick <= 1'b0;
    end
  end

  // **********************************************************************
  // Timers
  // **********************************************************************
  phase_timer #(.W(TIME_W)) u_phase_timer (
    .clk(clk),
    .rst(rst),
    .tick(bd_tick),
    .load(phase_load),
    .load_value(phase_value),
    .done(phase_done)
  );

  // Active protection runs alongside pre-discharge and discharge
  phase_timer #(.W(TIME_W)) u_prot_timer (
    .clk(clk),
    .rst(rst),
    .tick(bd_tick),
    .load(prot_load),
    .load_value(active_protect_time),
    .done(prot_done)
  );

  // **********************************************************************
  // Phase sequencing
  // **********************************************************************
  always_comb
  begin
    next_state = state;
    phase_load = 1'b0;
    phase_value = '0;
    prot_load = 1'b0;
    if (!bridge_pwm_enable)
      next_state = gate_seq_pkg::ST_IDLE;
    else if (rise)
    begin
      phase_load = 1'b1;
      if (active_freewheel_sel)
      begin
        next_state = gate_seq_pkg::ST_ON_CCP;
        phase_value = freewheel_protect_time;
      end
      else if (no_pre)
        next_state = gate_seq_pkg::ST_ON_CHG;
      else
      begin
        next_state = gate_seq_pkg::ST_ON_PRE;
        phase_value = precharge_duration;
      end
    end
    else if (fall)
    begin
      phase_load = 1'b1;
      if (active_freewheel_sel)
      begin
        next_state = gate_seq_pkg::ST_OFF_SYM;
        phase_value = freewheel_protect_time;
      end
      else
      begin
        prot_load = 1'b1;
        next_state = no_pre ? gate_seq_pkg::ST_OFF_DIS : gate_seq_pkg::ST_OFF_PRE;
        phase_value = predischarge_duration;
      end
    end
    else
    begin
      case (state)
        gate_seq_pkg::ST_ON_CCP:
          if (phase_done)
          begin
            phase_load = 1'b1;
            phase_value = precharge_duration;
            next_state = no_pre ? gate_seq_pkg::ST_ON_CHG : gate_seq_pkg::ST_ON_PRE;
          end
        gate_seq_pkg::ST_ON_PRE:
          if (phase_done)
            next_state = gate_seq_pkg::ST_ON_CHG;
        gate_seq_pkg::ST_ON_CHG:
          if (on_trip)
          begin
            phase_load = 1'b1;
            phase_value = drain_source_filter_time;
            next_state = gate_seq_pkg::ST_ON_POST;
          end
        gate_seq_pkg::ST_ON_POST:
          if (phase_done)
            next_state = gate_seq_pkg::ST_ON_HOLD;
        gate_seq_pkg::ST_OFF_SYM:
          if (phase_done)
          begin
            phase_load = 1'b1;
            prot_load = 1'b1;
            phase_value = predischarge_duration;
            next_state = no_pre ? gate_seq_pkg::ST_OFF_DIS : gate_seq_pkg::ST_OFF_PRE;
          end
        gate_seq_pkg::ST_OFF_PRE:
          if (phase_done)
            next_state = gate_seq_pkg::ST_OFF_DIS;
        gate_seq_pkg::ST_OFF_DIS:
          if (prot_done)
          begin
            phase_load = 1'b1;
            phase_value = drain_source_filter_time;
            next_state = gate_seq_pkg::ST_OFF_FW;
          end
        gate_seq_pkg::ST_OFF_FW:
          if (phase_done)
            next_state = gate_seq_pkg::ST_OFF_HOLD;
        default:
          next_state = state;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= gate_seq_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // **********************************************************************
  // Post-charge ramp
  // **********************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ramp <= gate_seq_pkg::CUR_RESET;
    else if (state == gate_seq_pkg::ST_ON_CHG)
      ramp <= charge_current_code;
    else if (state == gate_seq_pkg::ST_ON_POST && bd_tick && ramp < max_current_code)
      ramp <= ramp + 1'b1;
  end

  // **********************************************************************
  // Delay measurement and adaptation
  // **********************************************************************
  // Turn-on delay runs from pre-charge (or charge) start to the on trip
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      on_cnt <= gate_seq_pkg::DLY_RESET;
    else if (state != gate_seq_pkg::ST_ON_PRE && state != gate_seq_pkg::ST_ON_CHG)
      on_cnt <= gate_seq_pkg::DLY_RESET;
    else if (bd_tick && on_cnt != gate_seq_pkg::DLY_MAX)
      on_cnt <= on_cnt + 1'b1;
  end

  // Turn-off delay runs from pre-discharge (or discharge) start to the off trip
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      off_cnt <= gate_seq_pkg::DLY_RESET;
      off_meas <= 1'b0;
    end
    else if ((next_state == gate_seq_pkg::ST_OFF_PRE || next_state == gate_seq_pkg::ST_OFF_DIS)
             && state != gate_seq_pkg::ST_OFF_PRE && state != gate_seq_pkg::ST_OFF_DIS)
    begin
      off_cnt <= gate_seq_pkg::DLY_RESET;
      off_meas <= 1'b1;
    end
    // A new rise of any kind ends an unfinished turn-off measurement
    else if (off_update || next_state == gate_seq_pkg::ST_IDLE || next_state == gate_seq_pkg::ST_ON_CCP
             || next_state == gate_seq_pkg::ST_ON_PRE || next_state == gate_seq_pkg::ST_ON_CHG)
      off_meas <= 1'b0;
    else if (off_meas && bd_tick && off_cnt != gate_seq_pkg::DLY_MAX)
      off_cnt <= off_cnt + 1'b1;
  end

  // Single trip per sequence gives at most one update per PWM cycle
  assign on_update = (state == gate_seq_pkg::ST_ON_CHG) && on_trip && next_state == gate_seq_pkg::ST_ON_POST;
  assign off_update = off_meas && fw_ok;
  assign on_long = on_cnt > target_turn_on_delay;
  assign off_long = off_cnt > target_turn_off_delay;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      turn_on_delay <= gate_seq_pkg::DLY_RESET;
      turn_off_delay <= gate_seq_pkg::DLY_RESET;
    end
    else
    begin
      if (on_update)
        turn_on_delay <= on_cnt;
      if (off_update)
        turn_off_delay <= off_cnt;
    end
  end

  adaptive_current #(.W(CUR_W)) u_precharge (
    .clk(clk),
    .rst(rst),
    .init_load(init_load),
    .init_code(initial_precharge_code),
    .max_code(max_current_code),
    .adapt_en(gate_control_mode[gate_seq_pkg::MODE_ADAPT_BIT]),
    .filter_sel(adapt_filter_sel),
    .step_sel(adapt_step_sel),
    .update(on_update),
    .longer(on_long),
    .shorter(on_cnt < target_turn_on_delay),
    .code(pre_code)
  );

  adaptive_current #(.W(CUR_W)) u_predischarge (
    .clk(clk),
    .rst(rst),
    .init_load(init_load),
    .init_code(initial_predischarge_code),
    .max_code(max_current_code),
    .adapt_en(gate_control_mode[gate_seq_pkg::MODE_ADAPT_BIT]),
    .filter_sel(adapt_filter_sel),
    .step_sel(adapt_step_sel),
    .update(off_update),
    .longer(off_long),
    .shorter(off_cnt < target_turn_off_delay),
    .code(predis_code)
  );

  // **********************************************************************
  // Gate drive
  // **********************************************************************
  always_comb
  begin
    act_src = 1'b0;
    act_snk = 1'b1;
    act_code = discharge_current_code;
    fw_src = 1'b0;
    fw_snk = 1'b1;
    fw_code = freewheel_current_code;
    case (state)
      gate_seq_pkg::ST_ON_PRE:
      begin
        act_src = 1'b1;
        act_snk = 1'b0;
        act_code = pre_code;
      end
      gate_seq_pkg::ST_ON_CHG:
      begin
        act_src = 1'b1;
        act_snk = 1'b0;
        act_code = charge_current_code;
      end
      gate_seq_pkg::ST_ON_POST, gate_seq_pkg::ST_ON_HOLD, gate_seq_pkg::ST_OFF_SYM:
      begin
        act_src = 1'b1;
        act_snk = 1'b0;
        act_code = ramp;
      end
      gate_seq_pkg::ST_OFF_PRE:
        act_code = predis_code;
      gate_seq_pkg::ST_OFF_FW:
      begin
        fw_src = active_freewheel_sel && fw_ok;
        fw_snk = !fw_src;
      end
      gate_seq_pkg::ST_OFF_HOLD:
      begin
        fw_src = active_freewheel_sel;
        fw_snk = !fw_src;
      end
      default:
        act_code = discharge_current_code;
    endcase
  end

  // Registered outputs; mapping swaps the two gates
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hs_source <= 1'b0;
      hs_sink <= 1'b0;
      hs_current <= gate_seq_pkg::CUR_RESET;
      ls_source <= 1'b0;
      ls_sink <= 1'b0;
      ls_current <= gate_seq_pkg::CUR_RESET;
    end
    else if (pwm_on_low_side)
    begin
      ls_source <= act_src;
      ls_sink <= act_snk;
      ls_current <= act_code;
      hs_source <= fw_src;
      hs_sink <= fw_snk;
      hs_current <= fw_code;
    end
    else
    begin
      hs_source <= act_src;
      hs_sink <= act_snk;
      hs_current <= act_code;
      ls_source <= fw_src;
      ls_sink <= fw_snk;
      ls_current <= fw_code;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      adaptive_precharge_current <= gate_seq_pkg::CUR_RESET;
      adaptive_predischarge_current <= gate_seq_pkg::CUR_RESET;
    end
    else
    begin
      adaptive_precharge_current <= pre_code;
      adaptive_predischarge_current <= predis_code;
    end
  end

  // **********************************************************************
  // Assertions
  // **********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_rise_starts_ccp: assert property (bridge_pwm_enable && rise && active_freewheel_sel
    |=> state == gate_seq_pkg::ST_ON_CCP && fw_snk && !act_src) else $error("rise did not start protection");
  a_ccp_then_pre: assert property (state == gate_seq_pkg::ST_ON_CCP && phase_done && !no_pre
    && bridge_pwm_enable && !rise && !fall |=> state == gate_seq_pkg::ST_ON_PRE && act_code == pre_code)
    else $error("pre-charge did not follow protection");
  a_trip_ends_charge: assert property (state == gate_seq_pkg::ST_ON_CHG && on_trip && bridge_pwm_enable
    && !rise && !fall |=> state == gate_seq_pkg::ST_ON_POST ##1 turn_on_delay == $past(on_cnt, 2))
    else $error("charge did not end at trip");
  a_ramp_steps: assert property (state == gate_seq_pkg::ST_ON_POST && $past(state) == gate_seq_pkg::ST_ON_POST
    && bd_tick && ramp < max_current_code |=> ramp == $past(ramp) + 1'b1) else $error("ramp did not step");
  a_init_loads_min: assert property (init_load |=> pre_code == (($past(initial_precharge_code)
    < $past(max_current_code)) ? $past(initial_precharge_code) : $past(max_current_code)))
    else $error("pre-charge init wrong");
  a_fall_symmetry: assert property (bridge_pwm_enable && fall && active_freewheel_sel
    |=> state == gate_seq_pkg::ST_OFF_SYM && act_src) else $error("falling edge not delayed");
  a_prot_ends_dis: assert property (state == gate_seq_pkg::ST_OFF_DIS && prot_done && bridge_pwm_enable
    && !rise && !fall |=> state == gate_seq_pkg::ST_OFF_FW) else $error("discharge outlived protection");
  a_fw_below_low: assert property (state == gate_seq_pkg::ST_OFF_FW
    |=> ($past(pwm_on_low_side) ? hs_source : ls_source) == $past(active_freewheel_sel && fw_ok))
    else $error("freewheel charged above threshold");
  a_passive_fw_off: assert property (!active_freewheel_sel |-> !fw_src ##1 !($past(pwm_on_low_side) ? hs_source
    : ls_source) || $past(active_freewheel_sel)) else $error("complementary gate turned on");
  a_mode_skips_pre: assert property (bridge_pwm_enable && rise && !active_freewheel_sel && no_pre
    |=> state == gate_seq_pkg::ST_ON_CHG) else $error("pre-charge not skipped");
  a_adapt_hold: assert property (!gate_control_mode[gate_seq_pkg::MODE_ADAPT_BIT] && !init_load
    |=> $stable(pre_code) && $stable(predis_code)) else $error("current adapted in fixed mode");

  c_full_on: cover property (state == gate_seq_pkg::ST_ON_PRE ##[1:300] state == gate_seq_pkg::ST_ON_HOLD);
  c_full_off: cover property (state == gate_seq_pkg::ST_OFF_SYM ##[1:300] state == gate_seq_pkg::ST_OFF_HOLD);
  c_adapt_up: cover property (on_update && on_long && gate_control_mode[gate_seq_pkg::MODE_ADAPT_BIT]);
  c_low_side: cover property (pwm_on_low_side && state == gate_seq_pkg::ST_ON_POST);
endmodule

// file: tb/gate_model.sv
// Behavioural MOSFET of the PWM-side gate and switch node of one half-bridge
`timescale 1ns/1ns
module gate_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic src,
  input wire logic snk,
  input wire logic low_side,
  input wire logic [7:0] dly,
  output logic sw_high,
  output logic sw_low
);
  logic [7:0] cnt;
  logic on;
  // Gate needs dly+1 cycles of drive before the node moves
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 8'h00;
      on <= 1'b0;
    end
    else if ((src || snk) && src != on)
    begin
      cnt <= (cnt >= dly) ? 8'h00 : cnt + 8'h01;
      if (cnt >= dly)
        on <= src;
    end
    else
      cnt <= 8'h00;
  end
  assign sw_high = on ^ low_side;
  assign sw_low = !sw_high;
endmodule

// file: tb/gate_drive_sequencer_tb_top.sv
// Testbench of the gate-drive sequencer
`timescale 1ns/1ns
module gate_drive_sequencer_tb_top;
  logic clk, rst, pwm, low, en, stb, afw, filt, step, sh, sl, comp_on;
  logic hsrc, hsnk, lsrc, lsnk;
  logic [1:0] mode;
  logic [5:0] maxc, ipc, ipd, cur, dc, hc, lc, apc, apd, onc, erc;
  logic [7:0] dly, tp, ta, tg, ton, toff;
  int failures, n_tests, cyc;
  gate_drive_sequencer #(.BD_DIV(2)) i_gate_drive_sequencer (.clk(clk), .rst(rst), .pwm_input(pwm),
    .pwm_on_low_side(low), .bridge_pwm_enable(en), .enable_write_strobe(stb), .active_freewheel_sel(afw),
    .gate_control_mode(mode), .adapt_filter_sel(filt), .adapt_step_sel(step), .max_current_code(maxc),
    .charge_current_code(cur), .discharge_current_code(dc), .freewheel_current_code(cur),
    .initial_precharge_code(ipc), .initial_predischarge_code(ipd), .precharge_duration(tp),
    .predischarge_duration(tp), .freewheel_protect_time(tp), .active_protect_time(ta),
    .drain_source_filter_time(tp), .target_turn_on_delay(tg), .target_turn_off_delay(tg),
    .switch_node_high_threshold(sh), .switch_node_low_threshold(sl), .hs_source(hsrc), .hs_sink(hsnk),
    .hs_current(hc), .ls_source(lsrc), .ls_sink(lsnk), .ls_current(lc), .turn_on_delay(ton),
    .turn_off_delay(toff), .adaptive_precharge_current(apc), .adaptive_predischarge_current(apd));
  gate_model i_gate_model (.clk(clk), .rst(rst), .src(low ? lsrc : hsrc), .snk(low ? lsnk : hsnk),
    .low_side(low), .dly(dly), .sw_high(sh), .sw_low(sl));
  // ****
  // Clock, watchdog and helpers
  // ****
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Complementary gate sourcing seen since last clear
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (low ? hsrc : lsrc)
      comp_on <= 1'b1;
    if (cyc == 30000)
    begin
      failures++;
      test_done;
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task load;
    @(negedge clk) stb = 1;
    @(negedge clk) stb = 0;
    repeat (4) @(negedge clk);
  endtask
  // Fixed wait: no completion flag exists, 120 clocks cover every phase
  task cycle(input logic [7:0] d);
    dly = d;
    @(negedge clk) pwm = 1;
    repeat (3) @(negedge clk);
    erc = low ? lc : hc;
    repeat (117) @(negedge clk);
    onc = low ? lc : hc;
    pwm = 0;
    repeat (120) @(negedge clk);
  endtask
  task tend(input int n);
    $display("test %0d done", n);
  endtask
  task test_done;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    {rst, en, afw} = 3'h7;
    {pwm, low, stb, filt, step, comp_on} = 6'h00;
    {failures, n_tests} = 0;
    mode = 2'h2;
    {maxc, ipc, ipd, cur, dc} = {6'h03, 6'h05, 6'h02, 6'h04, 6'h06};
    {dly, tp, ta, tg} = {8'h02, 8'h03, 8'h08, 8'h04};
    repeat (20) @(negedge clk);
    check(8'({hsrc, lsrc, hsnk, lsnk}), 8'h00);
    check(8'(apc), 8'h00);
    rst = 0;
    tend(1);
    load;
    check(8'(apc), 8'h03);
    check(8'(apd), 8'h02);
    maxc = 6'h08;
    tend(2);
    cycle(14);
    check(8'(apc), 8'h04);
    check(8'(apd), 8'h03);
    check(8'(ton > tg), 8'h01);
    check(8'(toff > tg), 8'h01);
    check(8'(comp_on), 8'h01);
    check(8'(erc), 8'h06);
    check(8'(onc), 8'h07);
    check(8'(hc), 8'h06);
    check(8'(lc), 8'h04);
    step = 1;
    cycle(2);
    check(8'(apc), 8'h02);
    check(8'(apd), 8'h01);
    cycle(2);
    check(8'(apc), 8'h00);
    check(8'(apd), 8'h00);
    tend(3);
    {filt, step} = 2'h2;
    load;
    cycle(14);
    check(8'(apc), 8'h05);
    check(8'(apd), 8'h02);
    cycle(14);
    check(8'(apc), 8'h06);
    check(8'(apd), 8'h03);
    tend(4);
    {mode, filt} = 3'h2;
    load;
    cycle(14);
    check(8'(apc), 8'h05);
    tend(5);
    {mode, afw, low} = 4'h9;
    comp_on = 0;
    cycle(14);
    check(8'(comp_on), 8'h00);
    check(8'(apc), 8'h06);
    check(8'(erc), 8'h05);
    check(8'(onc), 8'h07);
    tend(6);
    {mode, low} = 3'h0;
    cycle(14);
    check(8'(erc), 8'h04);
    check(8'(apc), 8'h06);
    check(8'(onc), 8'h07);
    tend(7);
    test_done;
  end
endmodule
